/* hdl/ebr_defines.svh */
/*
 * timing and field constants for the external bus release handshake.
 * assumes a single 200 MHz system clock and synchronous reset.
 */
`ifndef EBR_DEFINES_SVH
`define EBR_DEFINES_SVH

// ---------------------------------------------------------------
// clock and timing
// ---------------------------------------------------------------
`define EBR_CLK_PERIOD_NS 5
`define EBR_SYNC_STAGES 3
// time in ns the bus stays floated before the grant goes low
`define EBR_FLOAT_SETTLE_NS 5
`define EBR_FLOAT_SETTLE_CYC \
    ((`EBR_FLOAT_SETTLE_NS + `EBR_CLK_PERIOD_NS - 1) / `EBR_CLK_PERIOD_NS)

// ---------------------------------------------------------------
// config and trip reset values
// ---------------------------------------------------------------
`define EBR_CFG_REQ_IGNORE_RST 1'b0
`define EBR_TRIP_EN_RST 1'b0

`endif

/* hdl/ebr_pkg.sv */
/*
 * types shared by the bus release handshake files.
 * assumes nothing beyond a SystemVerilog compiler.
 */
package ebr_pkg;
    // ---------------------------------------------------------------
    // handshake states
    // ---------------------------------------------------------------
    typedef enum logic [2:0] {
        EBR_OWN,
        EBR_DRAIN,
        EBR_FLOAT,
        EBR_GRANTED,
        EBR_RETURN
    } ebr_state_e;

    // external interface pin drive controls
    typedef struct packed {
        logic bus_oe;
        logic grant_n;
        logic grant_oe;
    } ebr_pins_s;
endpackage

/* hdl/ebr_sync.sv */
/*
 * three-stage pin synchroniser; a change is passed on once stages
 * two and three agree. assumes input is asynchronous to i_mclk.
 */
module ebr_sync
    import ebr_pkg::*;
#(
    parameter logic RST_VAL = 1'b1
) (
    input wire logic i_mclk,  // system clock
    input wire logic i_rst_n, // sync reset, active low
    input wire logic i_pin,   // asynchronous pin level
    output logic o_level      // filtered level
);
    // ---------------------------------------------------------------
    // synchroniser chain
    // ---------------------------------------------------------------
    logic [2:0] stage;
    logic [2:0] next_stage;
    logic next_level;

    // shift in; stage 0 feeds only stage 1
    always_comb begin
        next_stage = {stage[1:0], i_pin};
        next_level = (stage[1] == stage[2]) ? stage[2] : o_level;
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            stage <= {3{RST_VAL}};
            o_level <= RST_VAL;
        end else begin
            stage <= next_stage;
            o_level <= next_level;
        end
    end
endmodule

/* hdl/ebr_handshake.sv */
/*
 * release request / grant handshake of the external memory interface,
 * with the shared trip pins. assumes the access engine reports its
 * busy and queued state on i_access_busy and i_access_pending.
 */
module ebr_handshake
    import ebr_pkg::*;
(
    input wire logic i_mclk,            // system clock
    input wire logic i_rst_n,           // sync reset, active low
    input wire logic i_trip_three_n,    // shared request / trip 3 pin
    input wire logic i_shared_pin_in,   // trip 4 / grant pin input
    input wire logic i_req_ignore,      // request-ignore config bit
    input wire logic i_pin_dir_out,     // shared pin direction, 1 = out
    input wire logic i_trip_en,         // software trip enable
    input wire logic i_access_busy,     // access in progress
    input wire logic i_access_pending,  // access queued
    output logic o_bus_oe,              // drive address/data/strobes
    output logic o_hold_off,            // stop new accesses starting
    output logic o_grant_n,             // grant pin output value
    output logic o_grant_oe,            // grant pin output enable
    output logic o_trip_three,          // trip 3 event to pwm
    output logic o_trip_four,           // trip 4 event to pwm
    output logic o_released             // status: bus is released
);
`include "ebr_defines.svh"

    // ---------------------------------------------------------------
    // pin synchronisers
    // ---------------------------------------------------------------
    logic req_pin;
    logic shared_pin;

    ebr_sync #(.RST_VAL(1'b1)) u_sync_req (
        .i_mclk(i_mclk),
        .i_rst_n(i_rst_n),
        .i_pin(i_trip_three_n),
        .o_level(req_pin)
    );

    ebr_sync #(.RST_VAL(1'b1)) u_sync_shared (
        .i_mclk(i_mclk),
        .i_rst_n(i_rst_n),
        .i_pin(i_shared_pin_in),
        .o_level(shared_pin)
    );

    // ---------------------------------------------------------------
    // request qualification
    // ---------------------------------------------------------------
    logic req_active;
    logic idle;
    assign req_active = !req_pin && !i_req_ignore;
    assign idle = !i_access_busy && !i_access_pending;

    // ---------------------------------------------------------------
    // handshake state machine
    // ---------------------------------------------------------------
    localparam int SETTLE = `EBR_FLOAT_SETTLE_CYC;
    ebr_state_e state;
    ebr_state_e next_state;
    logic [3:0] settle_cnt;
    logic [3:0] next_settle_cnt;
    ebr_pins_s pins;
    ebr_pins_s next_pins;
    logic next_hold_off;
    logic next_released;

    always_comb begin
        next_state = state;
        next_settle_cnt = settle_cnt;
        case (state)
            EBR_OWN: begin
                if (req_active) begin
                    next_state = EBR_DRAIN;
                end
            end
            EBR_DRAIN: begin
                if (!req_active) begin
                    next_state = EBR_OWN;
                end else if (idle) begin
                    next_state = EBR_FLOAT;
                    next_settle_cnt = 4'(SETTLE);
                end
            end
            EBR_FLOAT: begin
                // buses already high-z; let them settle before grant
                if (settle_cnt > 4'h1) begin
                    next_settle_cnt = settle_cnt - 4'h1;
                end else begin
                    next_state = EBR_GRANTED;
                end
            end
            EBR_GRANTED: begin
                if (!req_active) begin
                    next_state = EBR_RETURN;
                end
            end
            EBR_RETURN: begin
                // grant is high now; bus drives again next cycle
                next_state = EBR_OWN;
            end
            default: begin
                next_state = EBR_OWN;
            end
        endcase
    end

    // bus and grant pin controls follow the next state, grant_oe the direction bit, so outputs stay registered
    always_comb begin
        next_pins.bus_oe = (next_state == EBR_OWN) ||
            (next_state == EBR_DRAIN);
        next_pins.grant_n = (next_state != EBR_GRANTED);
        next_pins.grant_oe = i_pin_dir_out;
        next_released = !next_pins.bus_oe;
        // hold-off rises with the drain state itself, so no access can
        // start in the very cycle in which idle is judged
        next_hold_off = (next_state != EBR_OWN);
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            state <= EBR_OWN;
            settle_cnt <= 4'h0;
            pins <= '{bus_oe: 1'b1, grant_n: 1'b1, grant_oe: 1'b0};
            o_hold_off <= 1'b0;
            o_released <= 1'b0;
        end else begin
            state <= next_state;
            settle_cnt <= next_settle_cnt;
            pins <= next_pins;
            o_hold_off <= next_hold_off;
            o_released <= next_released;
        end
    end

    assign o_bus_oe = pins.bus_oe;
    assign o_grant_n = pins.grant_n;
    assign o_grant_oe = pins.grant_oe;

    // ---------------------------------------------------------------
    // trip routing to the pwm modules
    // ---------------------------------------------------------------
    logic next_trip_three;
    logic next_trip_four;

    // trips stay quiet until enabled; the grant direction hides trip 4
    always_comb begin
        next_trip_three = i_trip_en && !req_pin;
        next_trip_four = i_trip_en && !i_pin_dir_out &&
            !shared_pin;
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            o_trip_three <= `EBR_TRIP_EN_RST;
            o_trip_four <= `EBR_TRIP_EN_RST;
        end else begin
            o_trip_three <= next_trip_three;
            o_trip_four <= next_trip_four;
        end
    end

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    // grant low only over a floated bus, and only after it floated
    a_float_when_granted: assert property (@(posedge i_mclk)
        disable iff (!i_rst_n) !o_grant_n |-> !o_bus_oe)
        else $error("grant low while bus driven");

    a_grant_after_float: assert property (@(posedge i_mclk)
        disable iff (!i_rst_n) $fell(o_grant_n) |-> !$past(o_bus_oe))
        else $error("grant fell before bus floated");

    // the drain keeps the bus until the access engine is quiet
    a_drain_first: assert property (@(posedge i_mclk)
        disable iff (!i_rst_n)
        (state == EBR_DRAIN && !idle) |=> o_bus_oe)
        else $error("bus released during access");

    a_float_idle: assert property (@(posedge i_mclk)
        disable iff (!i_rst_n) $fell(o_bus_oe) |->
        !$past(i_access_busy) && !$past(i_access_pending))
        else $error("bus floated with an access open");

    a_hold_drain: assert property (@(posedge i_mclk)
        disable iff (!i_rst_n) (state == EBR_DRAIN) |-> o_hold_off)
        else $error("new access allowed while draining");

    a_hold_float: assert property (@(posedge i_mclk)
        disable iff (!i_rst_n) !o_bus_oe |-> o_hold_off && o_released)
        else $error("access allowed while bus floated");

    // a request that is ignored or withdrawn never floats the bus
    a_ignore_blocks: assert property (@(posedge i_mclk)
        disable iff (!i_rst_n)
        (state == EBR_OWN && i_req_ignore) |=> state == EBR_OWN)
        else $error("request taken while ignored");

    a_abort_drain: assert property (@(posedge i_mclk)
        disable iff (!i_rst_n) (state == EBR_DRAIN && !req_active) |=>
        o_bus_oe && o_grant_n)
        else $error("withdrawn request floated the bus");

    // trips and the shared pin direction
    a_trip_gated: assert property (@(posedge i_mclk)
        disable iff (!i_rst_n) !$past(i_trip_en) |->
        !o_trip_three && !o_trip_four)
        else $error("trip passed while disabled");

    a_pin_dir: assert property (@(posedge i_mclk)
        disable iff (!i_rst_n)
        $past(i_rst_n) |-> o_grant_oe == $past(i_pin_dir_out))
        else $error("grant enable does not follow direction");

    // the grant stands while requested, then the bus comes back
    a_grant_holds: assert property (@(posedge i_mclk)
        disable iff (!i_rst_n) (!o_grant_n && req_active) |=> !o_grant_n)
        else $error("grant dropped while still requested");

    a_release_order: assert property (@(posedge i_mclk)
        disable iff (!i_rst_n) $rose(o_grant_n) |-> !o_bus_oe ##1 o_bus_oe)
        else $error("bus not resumed after grant rose");

    a_grant_bound: assert property (@(posedge i_mclk)
        disable iff (!i_rst_n) (state == EBR_FLOAT) |-> ##[1:15] !o_grant_n)
        else $error("grant late after float");
endmodule

/* tb/ebr_master_model.sv */
/*
 * behavioural external bus master that asks for the shared bus.
 * assumes the bench pulses i_go and drives nothing else on the pin.
 */
module ebr_master_model (
    input wire logic i_mclk,    // system clock
    input wire logic i_go,      // start one request
    input wire logic i_grant_n, // grant level seen on the pin
    output logic o_req_n,       // request pin, active low
    output logic o_done         // request removed
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        o_req_n = 1'b1;
        o_done = 1'b0;
    end
    // ask, wait bounded for the grant, use the bus, then let go
    always @(posedge i_go) begin : run
        int n;
        @(negedge i_mclk);
        o_req_n <= 1'b0;
        o_done <= 1'b0;
        n = 0;
        while (i_grant_n !== 1'b0 && n < 100) begin
            @(negedge i_mclk);
            n++;
        end
        repeat (20) @(negedge i_mclk);
        o_req_n <= 1'b1;
        o_done <= 1'b1;
    end
endmodule

/* tb/ext_bus_release_handshake_bench.sv */
/*
 * self-checking bench for the bus release handshake.
 * assumes the master model drives the request pin; the bench plays
 * the access engine, the config bits and the trip 4 source.
 */
module ext_bus_release_handshake_bench;
    timeunit 1ns;
    timeprecision 100ps;
    import ebr_pkg::*;
    logic i_mclk = 1'b0, i_rst_n = 1'b0, go = 1'b0, trip4_n = 1'b1;
    logic req_ign = 1'b0, dir_out = 1'b1, trip_en = 1'b0;
    logic busy = 1'b0, pend = 1'b0, req_n, done;
    logic bus_oe, hold_off, grant_n, grant_oe, trip3, trip4, released;
    logic pin;
    int miscompares = 0, n_tests = 0, cycles = 0;
    // the shared pin shows the grant only while the device drives it
    assign pin = grant_oe ? grant_n : trip4_n;
    ebr_handshake ebr_handshake_i (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
        .i_trip_three_n(req_n), .i_shared_pin_in(pin),
        .i_req_ignore(req_ign), .i_pin_dir_out(dir_out),
        .i_trip_en(trip_en), .i_access_busy(busy),
        .i_access_pending(pend), .o_bus_oe(bus_oe), .o_hold_off(hold_off),
        .o_grant_n(grant_n), .o_grant_oe(grant_oe), .o_trip_three(trip3),
        .o_trip_four(trip4), .o_released(released));
    ebr_master_model ebr_master_model_i (.i_mclk(i_mclk), .i_go(go),
        .i_grant_n(pin), .o_req_n(req_n), .o_done(done));
    // ---------------------------------------------------------------
    // clock, timeout and reporting
    // ---------------------------------------------------------------
    initial begin
        forever #2.5 i_mclk = ~i_mclk;
    end
    // a hang is cut short well past the longest scenario
    always @(posedge i_mclk) begin
        cycles++;
        if (cycles == 3000) begin
            miscompares++;
            close_out();
        end
    end
    task automatic check(input logic seen, input logic exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        $display("tests %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic start_req();
        int n;
        go = 1'b0;
        @(negedge i_mclk);
        go = 1'b1;
        n = 0;
        while (req_n !== 1'b0 && n < 5) begin
            @(negedge i_mclk);
            n++;
        end
        go = 1'b0;
        check(req_n, 1'b0);
    endtask
    task automatic wait_done();
        int n;
        n = 0;
        while (done !== 1'b1 && n < 200) begin
            @(negedge i_mclk);
            n++;
        end
        check(done, 1'b1);
    endtask
    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    // release held off by a running and then a queued access
    task automatic t_drain();
        int n;
        busy = 1'b1;
        start_req();
        repeat (10) @(negedge i_mclk);
        check(bus_oe, 1'b1);
        check(hold_off, 1'b1);
        busy = 1'b0;
        pend = 1'b1;
        repeat (3) @(negedge i_mclk);
        check(bus_oe, 1'b1);
        pend = 1'b0;
        n = 0;
        while (bus_oe !== 1'b0 && n < 5) begin
            @(negedge i_mclk);
            n++;
        end
        check(bus_oe, 1'b0);
        check(grant_n, 1'b1);
        @(negedge i_mclk);
        check(grant_n, 1'b0);
        check(released, 1'b1);
        n = 0;
        while (grant_n !== 1'b1 && n < 40) begin
            check(bus_oe, 1'b0);
            @(negedge i_mclk);
            n++;
        end
        check(bus_oe, 1'b0);
        @(negedge i_mclk);
        check(bus_oe, 1'b1);
        check(released, 1'b0);
        check(hold_off, 1'b0);
        wait_done();
    endtask
    // ignore bit set: trip 3 low must not float the bus
    task automatic t_ignore();
        req_ign = 1'b1;
        start_req();
        repeat (8) @(negedge i_mclk);
        check(trip3, 1'b0);
        trip_en = 1'b1;
        repeat (2) @(negedge i_mclk);
        check(trip3, 1'b1);
        check(bus_oe, 1'b1);
        check(grant_n, 1'b1);
        check(hold_off, 1'b0);
        wait_done();
        // let the synchronised request rise before the bit clears
        repeat (6) @(negedge i_mclk);
        trip_en = 1'b0;
        req_ign = 1'b0;
    endtask
    // request withdrawn while an access still runs: no release
    task automatic t_abort();
        busy = 1'b1;
        start_req();
        wait_done();
        check(bus_oe, 1'b1);
        check(grant_n, 1'b1);
        check(hold_off, 1'b1);
        repeat (6) @(negedge i_mclk);
        busy = 1'b0;
        repeat (4) @(negedge i_mclk);
        check(hold_off, 1'b0);
        check(bus_oe, 1'b1);
        check(released, 1'b0);
    endtask
    // direction picks trip 4 input or grant output on the shared pin
    task automatic t_shared();
        dir_out = 1'b0;
        trip4_n = 1'b0;
        repeat (8) @(negedge i_mclk);
        check(trip4, 1'b0);
        trip_en = 1'b1;
        repeat (2) @(negedge i_mclk);
        check(grant_oe, 1'b0);
        check(trip4, 1'b1);
        dir_out = 1'b1;
        repeat (8) @(negedge i_mclk);
        check(grant_oe, 1'b1);
        check(trip4, 1'b0);
        trip_en = 1'b0;
        trip4_n = 1'b1;
    endtask
    // main sequence
    initial begin
        repeat (4) @(negedge i_mclk);
        check(bus_oe, 1'b1);
        check(grant_n, 1'b1);
        check(trip3, 1'b0);
        check(trip4, 1'b0);
        check(grant_oe, 1'b0);
        check(hold_off, 1'b0);
        check(released, 1'b0);
        i_rst_n = 1'b1;
        repeat (4) @(negedge i_mclk);
        t_drain();
        t_ignore();
        t_abort();
        t_shared();
        close_out();
    end
endmodule
